/* shared/pml_pkg.sv */
/*
 * Constants shared by the management pin logic: bus offsets, field positions,
 * management frame codes, EEPROM loader codes and timing counts.
 * Assumes a 50 MHz system clock and a 32-bit classic Wishbone master.
 */
package pml_pkg;

	localparam int PORTS          = 8;
	localparam int MEM_AW         = 8;
	localparam int MEM_DW         = 16;
	localparam int MEM_WORDS      = 256;

	localparam logic [7:0] OFF_CTRL    = 8'h00;
	localparam logic [7:0] OFF_STATUS  = 8'h04;
	localparam logic [7:0] OFF_INT_STS = 8'h08;
	localparam logic [7:0] OFF_INT_MSK = 8'h0c;

	localparam int CTRL_OVR   = 0;
	localparam int CTRL_EN    = 1;
	localparam int CTRL_SEL   = 2;
	localparam int STRAP_EN   = 0;
	localparam int STRAP_SEL  = 1;
	localparam int STS_EE     = 0;
	localparam int STS_DONE   = 1;
	localparam int STS_POL    = 8;
	localparam int INT_W      = 10;
	localparam int INT_MDIO_WR = 8;
	localparam int INT_EE_DONE = 9;

	localparam logic [2:0]       CTRL_RST = 3'h0;
	localparam logic [INT_W-1:0] MSK_RST  = 10'h000;

	localparam int MDC_MAX_KHZ     = 12500;
	localparam int REFCLK_LO_KHZ   = 125000;
	localparam int REFCLK_HI_KHZ   = 156250;

	localparam logic [5:0] PRE_LEN = 6'h20;
	localparam logic [1:0] ST_CODE = 2'h1;
	localparam logic [1:0] OP_RD   = 2'h2;
	localparam logic [1:0] OP_WR   = 2'h1;
	localparam logic [5:0] HDR_LAST = 6'h0d;
	localparam logic [5:0] DAT_LAST = 6'h0f;

	localparam logic [7:0] EE_DEV_WR = 8'ha0;
	localparam logic [7:0] EE_DEV_RD = 8'ha1;
	localparam logic [7:0] EE_WORD0  = 8'h00;
	localparam logic [8:0] EE_LAST   = 9'h1ff;
	localparam logic [8:0] CLR_LAST  = 9'h0ff;

	localparam int CLK_PERIOD_NS = 20;
	localparam int EE_QTR_NS     = 2500;
	localparam logic [6:0] EE_QTR_CYC = 7'((EE_QTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

endpackage

/* hw/pml_regmem.sv */
/*
 * Port register store: 256 words of 16 bits, one per port and register.
 * Assumes one writer or reader per cycle; read data is registered.
 */
module pml_regmem
	import pml_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              we,
	input  wire logic [MEM_AW-1:0] addr,
	input  wire logic [MEM_DW-1:0] wdata,
	output logic      [MEM_DW-1:0] rdata
);

	logic [MEM_DW-1:0] mem [0:MEM_WORDS-1];

	always_ff @(posedge clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		rdata <= mem[addr];
	end

endmodule

/* hw/pml_top.sv */
/*
 * Management pin logic: serial management slave, EEPROM loader, interrupt
 * pins with strapped polarity, device reset and reference clock output.
 * Assumes pins are raw asynchronous inputs and a classic Wishbone master.
 */
// Behaviour
// - Management clock runs up to 12.5 MHz; data shifts on its edges.
// - One shared data line carries both directions, aligned to rising clock edges.
// - Interrupt pin strap sampled at reset picks active-low or active-high drive.
// - EEPROM data line is checked at power-up and each reset release.
// - Line high means EEPROM present; low or floating means none.
// - With an EEPROM present, port configuration is loaded from it.
// - Device masters the EEPROM: drives its clock, uses data both ways.
// - While device reset is low, the device powers down and defaults registers.
// - Reference clock enable and frequency come from straps or a register.
// - Reference clock is inactive during reset and low when disabled.
module pml_top
	import pml_pkg::*;
(
	input  wire logic             mclk,
	input  wire logic             rst,
	input  wire logic             wb_cyc_i,
	input  wire logic             wb_stb_i,
	input  wire logic             wb_we_i,
	input  wire logic [7:0]       wb_adr_i,
	input  wire logic [3:0]       wb_sel_i,
	input  wire logic [31:0]      wb_dat_i,
	output logic      [31:0]      wb_dat_o,
	output logic                  wb_ack_o,
	output logic                  irq,
	input  wire logic             mdc,
	input  wire logic             mdio_i,
	output logic                  mdio_o,
	output logic                  mdio_oe,
	input  wire logic             device_reset_low,
	output logic                  device_powered_down,
	input  wire logic [PORTS-1:0] port_event,
	input  wire logic [PORTS-1:0] port_interrupt_out_i,
	output logic      [PORTS-1:0] port_interrupt_out_o,
	output logic      [PORTS-1:0] port_interrupt_out_oe,
	input  wire logic             eeprom_serial_data_i,
	output logic                  eeprom_serial_data_o,
	output logic                  eeprom_serial_data_oe,
	output logic                  eeprom_serial_clock,
	input  wire logic [7:0]       configuration_strap_pins,
	output logic                  reference_clock_output,
	output logic                  reference_clock_select
);

	typedef enum logic [1:0] {I_CHECK, I_CLEAR, I_LOAD, I_RUN} pml_init_t;
	typedef enum logic [1:0] {E_START, E_BYTE, E_STOP} pml_ee_t;
	typedef enum logic [2:0] {M_PRE, M_HDR, M_TA, M_RD, M_WR} pml_mdio_t;

	typedef struct packed {
		logic              mdc_s1;
		logic              mdc_s2;
		logic              mdc_s3;
		logic              mdi_s1;
		logic              mdi_s2;
		logic              nres_s1;
		logic              nres_s2;
		logic              ee_s1;
		logic              ee_s2;
		logic [PORTS-1:0]  irq_s1;
		logic [PORTS-1:0]  irq_s2;
		logic [7:0]        strap_s1;
		logic [7:0]        strap_s2;
		pml_init_t         ist;
		logic [8:0]        icnt;
		logic              ee_present;
		logic [PORTS-1:0]  int_pol_low;
		logic [1:0]        strap;
		pml_ee_t           est;
		logic [6:0]        qdiv;
		logic [1:0]        qph;
		logic [3:0]        bitn;
		logic [7:0]        sh;
		logic [2:0]        step;
		logic [7:0]        hi;
		logic              scl_low;
		logic              sda_low;
		pml_mdio_t         mst;
		logic [5:0]        mcnt;
		logic [13:0]       hdr;
		logic [15:0]       dat;
		logic              mdo;
		logic              mdoe;
		logic [2:0]        ctrl;
		logic [INT_W-1:0]  sts;
		logic [INT_W-1:0]  msk;
		logic              ack;
		logic [31:0]       rdat;
		logic              refclk;
		logic              we;
		logic [MEM_AW-1:0] addr;
		logic [MEM_DW-1:0] wdata;
	} pml_state_t;

	pml_state_t        q;
	pml_state_t        n;
	logic [MEM_DW-1:0] mem_rdata;
	logic              rst_int;
	logic              rise;
	logic              clk_en;
	logic              clk_sel;
	logic [13:0]       hdr_full;

	function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
		return adr[7:2] == off[7:2];
	endfunction

	function automatic logic [15:0] lanes(input logic [15:0] old, input logic [15:0] dw,
		input logic [3:0] sel);
		logic [15:0] m;
		m = {{8{sel[1]}}, {8{sel[0]}}};
		return (old & ~m) | (dw & m);
	endfunction

	pml_regmem u_mem (
		.clk   (mclk),
		.we    (q.we),
		.addr  (q.addr),
		.wdata (q.wdata),
		.rdata (mem_rdata)
	);

	assign rst_int  = rst | ~q.nres_s2;
	assign rise     = q.mdc_s2 & ~q.mdc_s3;
	assign clk_en   = q.ctrl[CTRL_OVR] ? q.ctrl[CTRL_EN] : q.strap[STRAP_EN];
	assign clk_sel  = q.ctrl[CTRL_OVR] ? q.ctrl[CTRL_SEL] : q.strap[STRAP_SEL];
	assign hdr_full = {q.hdr[12:0], q.mdi_s2};

	always_comb begin
		logic [INT_W-1:0] set;
		logic [INT_W-1:0] clr;
		logic [15:0]      wr16;
		logic             rd;
		logic             tick;
		set  = '0;
		clr  = '0;
		wr16 = 16'h0000;
		rd   = 1'b0;
		tick = 1'b0;
		n    = q;
		n.mdc_s1   = mdc;
		n.mdc_s2   = q.mdc_s1;
		n.mdc_s3   = q.mdc_s2;
		n.mdi_s1   = mdio_i;
		n.mdi_s2   = q.mdi_s1;
		n.nres_s1  = device_reset_low;
		n.nres_s2  = q.nres_s1;
		n.ee_s1    = eeprom_serial_data_i;
		n.ee_s2    = q.ee_s1;
		n.irq_s1   = port_interrupt_out_i;
		n.irq_s2   = q.irq_s1;
		n.strap_s1 = configuration_strap_pins;
		n.strap_s2 = q.strap_s1;
		n.we       = 1'b0;
		set[PORTS-1:0] = port_event;
		// Bus slave: request answered one cycle later, write lands on the ack edge.
		n.ack  = wb_cyc_i & wb_stb_i & ~q.ack;
		n.rdat = 32'h0000_0000;
		if (hit(wb_adr_i, OFF_CTRL)) begin
			n.rdat[2:0] = q.ctrl;
		end else if (hit(wb_adr_i, OFF_STATUS)) begin
			n.rdat[STS_EE]   = q.ee_present;
			n.rdat[STS_DONE] = q.ist == I_RUN;
			n.rdat[STS_POL+PORTS-1:STS_POL] = q.int_pol_low;
		end else if (hit(wb_adr_i, OFF_INT_STS)) begin
			n.rdat[INT_W-1:0] = q.sts;
		end else if (hit(wb_adr_i, OFF_INT_MSK)) begin
			n.rdat[INT_W-1:0] = q.msk;
		end
		if (q.ack && wb_cyc_i && wb_stb_i && wb_we_i) begin
			if (hit(wb_adr_i, OFF_CTRL)) begin
				wr16   = lanes({13'h0000, q.ctrl}, wb_dat_i[15:0], wb_sel_i);
				n.ctrl = wr16[2:0];
			end else if (hit(wb_adr_i, OFF_INT_STS)) begin
				clr = wb_dat_i[INT_W-1:0] & {{2{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
			end else if (hit(wb_adr_i, OFF_INT_MSK)) begin
				wr16  = lanes({6'h00, q.msk}, wb_dat_i[15:0], wb_sel_i);
				n.msk = wr16[INT_W-1:0];
			end
		end
		unique case (q.ist)
			I_CHECK: begin
				n.ee_present  = q.ee_s2;
				n.int_pol_low = q.irq_s2;
				n.strap       = q.strap_s2[1:0];
				n.icnt        = 9'h000;
				n.ist         = I_CLEAR;
			end
			I_CLEAR: begin
				n.we    = 1'b1;
				n.addr  = q.icnt[7:0];
				n.wdata = 16'h0000;
				n.icnt  = q.icnt + 9'h001;
				if (q.icnt == CLR_LAST) begin
					n.icnt = 9'h000;
					n.step = 3'h0;
					n.est  = E_START;
					n.qph  = 2'h0;
					n.qdiv = 7'h00;
					n.ist  = q.ee_present ? I_LOAD : I_RUN;
				end
			end
			I_LOAD: begin
				tick   = q.qdiv == EE_QTR_CYC - 7'h01;
				n.qdiv = tick ? 7'h00 : q.qdiv + 7'h01;
				rd     = q.step == 3'h5;
				if (tick) begin
					n.qph = q.qph + 2'h1;
					// Clock is always driven by this end; data line is open drain.
					unique case (q.est)
						E_START: begin
							unique case (q.qph)
								2'h0: begin
									n.scl_low = 1'b1;
									n.sda_low = 1'b0;
								end
								2'h1: n.scl_low = 1'b0;
								2'h2: n.sda_low = 1'b1;
								2'h3: begin
									n.scl_low = 1'b1;
									n.step    = q.step + 3'h1;
									n.est     = E_BYTE;
									n.bitn    = 4'h0;
									n.sh      = (q.step == 3'h0) ? EE_DEV_WR : EE_DEV_RD;
								end
							endcase
						end
						E_BYTE: begin
							unique case (q.qph)
								2'h0: begin
									if (q.bitn < 4'h8) begin
										n.sda_low = rd ? 1'b0 : ~q.sh[7];
									end else begin
										n.sda_low = rd & (q.icnt != EE_LAST);
									end
								end
								2'h1: n.scl_low = 1'b0;
								2'h2: begin
									if (q.bitn < 4'h8) begin
										n.sh = {q.sh[6:0], q.ee_s2};
									end
								end
								2'h3: begin
									n.scl_low = 1'b1;
									n.bitn    = q.bitn + 4'h1;
									if (q.bitn == 4'h8) begin
										n.bitn = 4'h0;
										if (rd) begin
											n.icnt = q.icnt + 9'h001;
											if (!q.icnt[0]) begin
												n.hi = q.sh;
											end else begin
												n.we    = 1'b1;
												n.addr  = q.icnt[8:1];
												n.wdata = {q.hi, q.sh};
											end
											if (q.icnt == EE_LAST) begin
												n.step = 3'h6;
												n.est  = E_STOP;
											end
										end else if (q.step == 3'h1) begin
											n.step = 3'h2;
											n.sh   = EE_WORD0;
										end else if (q.step == 3'h2) begin
											n.step = 3'h3;
											n.est  = E_START;
										end else begin
											n.step = 3'h5;
										end
									end
								end
							endcase
						end
						E_STOP: begin
							unique case (q.qph)
								2'h0: begin
									n.scl_low = 1'b1;
									n.sda_low = 1'b1;
								end
								2'h1: n.scl_low = 1'b0;
								2'h2: n.sda_low = 1'b0;
								2'h3: begin
									n.ist             = I_RUN;
									set[INT_EE_DONE]  = 1'b1;
								end
							endcase
						end
					endcase
				end
			end
			I_RUN: begin
				// Management slave: every step is taken on a rising management clock.
				if (rise) begin
					unique case (q.mst)
						M_PRE: begin
							if (q.mdi_s2) begin
								n.mcnt = (q.mcnt == PRE_LEN) ? PRE_LEN : q.mcnt + 6'h01;
							end else if (q.mcnt == PRE_LEN) begin
								n.mst  = M_HDR;
								n.hdr  = 14'h0000;
								n.mcnt = 6'h01;
							end else begin
								n.mcnt = 6'h00;
							end
						end
						M_HDR: begin
							n.hdr  = hdr_full;
							n.mcnt = q.mcnt + 6'h01;
							if (q.mcnt == HDR_LAST) begin
								n.mcnt = 6'h00;
								n.addr = {hdr_full[7:5], hdr_full[4:0]};
								if (hdr_full[13:12] == ST_CODE && hdr_full[9:8] == 2'h0 &&
									(hdr_full[11:10] == OP_RD || hdr_full[11:10] == OP_WR)) begin
									n.mst = M_TA;
								end else begin
									n.mst = M_PRE;
								end
							end
						end
						M_TA: begin
							n.mcnt = q.mcnt + 6'h01;
							if (q.hdr[11:10] == OP_RD && q.mcnt == 6'h00) begin
								n.mdoe = 1'b1;
								n.mdo  = 1'b0;
							end
							if (q.mcnt == 6'h01) begin
								n.mcnt = 6'h00;
								if (q.hdr[11:10] == OP_RD) begin
									n.dat = mem_rdata;
									n.mdo = mem_rdata[15];
									n.mst = M_RD;
								end else begin
									n.mst = M_WR;
								end
							end
						end
						M_RD: begin
							n.mcnt = q.mcnt + 6'h01;
							n.mdo  = q.dat[14];
							n.dat  = {q.dat[14:0], 1'b0};
							if (q.mcnt == DAT_LAST) begin
								n.mdoe = 1'b0;
								n.mdo  = 1'b0;
								n.mcnt = 6'h00;
								n.mst  = M_PRE;
							end
						end
						M_WR: begin
							n.mcnt = q.mcnt + 6'h01;
							n.dat  = {q.dat[14:0], q.mdi_s2};
							if (q.mcnt == DAT_LAST) begin
								n.we    = 1'b1;
								n.wdata = {q.dat[14:0], q.mdi_s2};
								n.mcnt  = 6'h00;
								n.mst   = M_PRE;
								set[INT_MDIO_WR] = 1'b1;
							end
						end
						default: n.mst = M_PRE;
					endcase
				end
			end
		endcase
		n.sts    = (q.sts & ~clr) | set;
		n.refclk = clk_en & ~q.refclk;
		if (rst_int) begin
			n = '0;
			n.mdc_s1   = mdc;
			n.mdc_s2   = q.mdc_s1;
			n.mdc_s3   = q.mdc_s2;
			n.mdi_s1   = mdio_i;
			n.mdi_s2   = q.mdi_s1;
			n.nres_s1  = device_reset_low;
			n.nres_s2  = q.nres_s1;
			n.ee_s1    = eeprom_serial_data_i;
			n.ee_s2    = q.ee_s1;
			n.irq_s1   = port_interrupt_out_i;
			n.irq_s2   = q.irq_s1;
			n.strap_s1 = configuration_strap_pins;
			n.strap_s2 = q.strap_s1;
			n.ctrl     = CTRL_RST;
			n.msk      = MSK_RST;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign wb_dat_o               = q.rdat;
	assign wb_ack_o               = q.ack;
	assign irq                    = |(q.sts & q.msk);
	assign mdio_o                 = q.mdo;
	assign mdio_oe                = q.mdoe;
	assign device_powered_down    = rst_int;
	assign port_interrupt_out_oe  = q.sts[PORTS-1:0] & q.msk[PORTS-1:0];
	assign port_interrupt_out_o   = ~q.int_pol_low;
	assign eeprom_serial_data_o   = 1'b0;
	assign eeprom_serial_data_oe  = q.sda_low;
	assign eeprom_serial_clock    = ~q.scl_low;
	assign reference_clock_output = q.refclk;
	assign reference_clock_select = clk_sel;

	default clocking @(posedge mclk); endclocking
	default disable iff (rst);

	sequence s_bus_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o && !rst_int;
	endsequence
	sequence s_ack_pulse;
		wb_ack_o ##1 !wb_ack_o;
	endsequence
	sequence s_rd_turn;
		q.mst == M_TA && rise && q.hdr[11:10] == OP_RD && q.mcnt == 6'h00;
	endsequence

	property p_ack;
		s_bus_req |=> s_ack_pulse;
	endproperty
	a_ack: assert property (p_ack) else $error("Bus ack not a single pulse.");

	property p_refclk_off;
		!clk_en |=> !reference_clock_output;
	endproperty
	a_refclk_off: assert property (p_refclk_off) else $error("Clock out not low.");

	property p_refclk_rst;
		rst_int |=> !reference_clock_output;
	endproperty
	a_refclk_rst: assert property (p_refclk_rst) else $error("Clock out in reset.");

	property p_defaults;
		rst_int |=> q.sts == '0 && q.ctrl == CTRL_RST && !irq && q.ist == I_CHECK;
	endproperty
	a_defaults: assert property (p_defaults) else $error("Reset left state.");

	property p_ee_check;
		q.ist == I_CHECK && !rst_int |=> q.ee_present == $past(q.ee_s2) && q.ist == I_CLEAR;
	endproperty
	a_ee_check: assert property (p_ee_check) else $error("EEPROM check wrong.");

	property p_no_ee;
		q.ist == I_CLEAR && q.icnt == CLR_LAST && !q.ee_present && !rst_int |=> q.ist == I_RUN;
	endproperty
	a_no_ee: assert property (p_no_ee) else $error("Load without EEPROM.");

	property p_scl_idle;
		q.ist != I_LOAD |-> eeprom_serial_clock && !eeprom_serial_data_oe;
	endproperty
	a_scl_idle: assert property (p_scl_idle) else $error("EEPROM pins busy.");

	property p_int_pol;
		q.ist == I_CHECK && !rst_int |=> q.int_pol_low == $past(q.irq_s2);
	endproperty
	a_int_pol: assert property (p_int_pol) else $error("Polarity not strapped.");

	property p_int_pin;
		port_event[0] && q.msk[0] && !rst_int |=> port_interrupt_out_oe[0];
	endproperty
	a_int_pin: assert property (p_int_pin) else $error("Interrupt pin idle.");

	property p_rd_turn;
		(s_rd_turn and !rst_int) |=> mdio_oe && !mdio_o;
	endproperty
	a_rd_turn: assert property (p_rd_turn) else $error("Turnaround not driven.");

	property p_wr_store;
		q.mst == M_WR && rise && q.mcnt == DAT_LAST && !rst_int |=> q.we && q.sts[INT_MDIO_WR];
	endproperty
	a_wr_store: assert property (p_wr_store) else $error("Write not stored.");

endmodule

/* dv/pml_mgmt_model.sv */
/*
 * Station manager model: drives the management clock and frames on the data line.
 * Assumes the bench resolves the line with a pull-up and feeds it back here.
 */
module pml_mgmt_model
	import pml_pkg::*;
(
	output logic     mdc,
	output logic     sm_oe,
	output logic     sm_o,
	input wire logic mdio_line
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		mdc = 1'b0;
		sm_oe = 1'b0;
		sm_o = 1'b1;
	end

	// Clock stands low between frames; 160 ns period is below the top rate.
	task automatic bit_cyc(input logic oe, input logic d, output logic s);
		sm_oe = oe;
		sm_o = oe ? d : ~d;
		#80 mdc = 1'b1;
		s = mdio_line;
		#80 mdc = 1'b0;
	endtask

	task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
			input logic [15:0] wd, output logic [15:0] rd);
		logic [63:0] w;
		logic s;
		#3;
		w = {32'hffffffff, ST_CODE, op, pa, ra, 2'b10, wd};
		rd = 16'h0;
		for (int i = 63; i >= 0; i--) begin
			bit_cyc(op == OP_WR || i > 17, w[i], s);
			if (i < 16)
				rd[i] = s;
		end
		sm_oe = 1'b0;
	endtask
endmodule

/* dv/pml_top_test.sv */
/*
 * Bench for the management pin logic: bus, link, interrupts, EEPROM, clock out.
 * Assumes pull resistors on the data and interrupt pins and the station manager model.
 */
module pml_top_test
	import pml_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic        mclk, rst, cyc, stb, we, ack, irq, mdc, sm_oe, sm_o, mdio_o, mdio_oe;
	logic        dev_n, pdown, sda_o, sda_oe, scl, ee_pull, rck, rsel;
	logic [3:0]  sel;
	logic [7:0]  adr, ev, pin_o, pin_oe, pull, strap;
	logic [31:0] wdat, dat_o, rdat;
	logic [15:0] d;
	int          err_count, cmp_count, n;
	wire         mdio_ln = mdio_oe ? mdio_o : (sm_oe ? sm_o : 1'b1);
	wire         sda_ln = sda_oe ? sda_o : ee_pull;
	wire [7:0]   pin = (pin_oe & pin_o) | (~pin_oe & pull);

	pml_top pml_top_i (.mclk(mclk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.irq(irq), .mdc(mdc), .mdio_i(mdio_ln), .mdio_o(mdio_o), .mdio_oe(mdio_oe),
		.device_reset_low(dev_n), .device_powered_down(pdown), .port_event(ev),
		.port_interrupt_out_i(pin), .port_interrupt_out_o(pin_o),
		.port_interrupt_out_oe(pin_oe), .eeprom_serial_data_i(sda_ln),
		.eeprom_serial_data_o(sda_o), .eeprom_serial_data_oe(sda_oe),
		.eeprom_serial_clock(scl), .configuration_strap_pins(strap),
		.reference_clock_output(rck), .reference_clock_select(rsel));

	pml_mgmt_model pml_mgmt_model_i (.mdc(mdc), .sm_oe(sm_oe), .sm_o(sm_o), .mdio_line(mdio_ln));

	task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic tick(int k);
		repeat (k) @(posedge mclk);
	endtask

	// Classic single cycle: hold the request until ack is sampled high.
	task automatic wb(logic w, logic [7:0] a, logic [31:0] v);
		int k;
		@(posedge mclk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= v;
		sel <= 4'hf;
		k = 0;
		do begin
			@(posedge mclk);
			k++;
		end while (ack !== 1'b1 && k < 50);
		rdat = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		check("bus ack", 32'(ack), 32'h1);
	endtask

	task automatic wait_done();
		int k;
		k = 0;
		do begin
			tick(20);
			wb(1'b0, OFF_STATUS, 32'h0);
			k++;
		end while (rdat[STS_DONE] !== 1'b1 && k < 40);
		check("init done", 32'(rdat[STS_DONE]), 32'h1);
	endtask

	task automatic toggles(output int t);
		logic p;
		t = 0;
		@(posedge mclk);
		p = rck;
		repeat (8) begin
			@(posedge mclk);
			t += int'(rck !== p);
			p = rck;
		end
	endtask

	task automatic wait_lvl(bit on_scl, logic v);
		int k;
		k = 0;
		while ((on_scl ? scl : sda_oe) !== v && k < 1000) begin
			@(posedge mclk);
			k++;
		end
		check("level wait", 32'(k < 1000), 32'h1);
	endtask

	task automatic dev_pulse(logic p);
		ee_pull <= p;
		dev_n <= 1'b0;
		tick(4);
		dev_n <= 1'b1;
	endtask

	task automatic t_defaults();
		wait_done();
		check("status", rdat, 32'h00000f02);
		wb(1'b0, OFF_INT_MSK, 32'h0);
		check("mask", rdat, 32'h0);
		wb(1'b0, 8'h10, 32'h0);
		check("unmapped", rdat, 32'h0);
		$display("defaults test done");
	endtask

	task automatic t_irq();
		ev <= 8'h21;
		@(posedge mclk);
		ev <= 8'h00;
		wb(1'b0, OFF_INT_STS, 32'h0);
		check("int status", rdat, 32'h21);
		check("pins masked", 32'(pin_oe), 32'h0);
		wb(1'b1, OFF_INT_MSK, 32'h21);
		tick(2);
		check("irq on", 32'(irq), 32'h1);
		check("pins on", 32'(pin), 32'h2e);
		wb(1'b1, OFF_INT_STS, 32'h1);
		tick(2);
		check("pins half", 32'(pin), 32'h2f);
		ev <= 8'h01;
		@(posedge mclk);
		ev <= 8'h00;
		tick(1);
		check("pins again", 32'(pin), 32'h2e);
		wb(1'b1, OFF_INT_STS, 32'h21);
		tick(2);
		check("irq off", 32'(irq), 32'h0);
		check("pins off", 32'(pin), 32'h0f);
		wb(1'b1, OFF_INT_MSK, 32'h0);
		$display("interrupt test done");
	endtask

	task automatic t_mgmt();
		pml_mgmt_model_i.frame(OP_WR, 5'd3, 5'd5, 16'ha5c3, d);
		tick(10);
		wb(1'b0, OFF_INT_STS, 32'h0);
		check("write event", rdat, 32'h100);
		wb(1'b1, OFF_INT_STS, 32'h100);
		pml_mgmt_model_i.frame(OP_RD, 5'd3, 5'd5, 16'h0, d);
		check("read back", 32'(d), 32'ha5c3);
		pml_mgmt_model_i.frame(OP_WR, 5'd8, 5'd5, 16'h1234, d);
		pml_mgmt_model_i.frame(OP_RD, 5'd0, 5'd5, 16'h0, d);
		check("bad port", 32'(d), 32'h0);
		pml_mgmt_model_i.frame(OP_WR, 5'd7, 5'd31, 16'h8001, d);
		pml_mgmt_model_i.frame(OP_RD, 5'd7, 5'd31, 16'h0, d);
		check("last word", 32'(d), 32'h8001);
		$display("management test done");
	endtask

	task automatic t_refclk();
		toggles(n);
		check("strap on", 32'(n), 32'h8);
		check("strap sel", 32'(rsel), 32'h1);
		wb(1'b1, OFF_CTRL, 32'h1);
		tick(3);
		toggles(n);
		check("reg off", 32'(n) | 32'(rck), 32'h0);
		wb(1'b1, OFF_CTRL, 32'h3);
		tick(3);
		toggles(n);
		check("reg on", 32'(n), 32'h8);
		check("reg sel lo", 32'(rsel), 32'h0);
		wb(1'b1, OFF_CTRL, 32'h7);
		tick(2);
		check("reg sel hi", 32'(rsel), 32'h1);
		wb(1'b1, OFF_CTRL, 32'h0);
		// Straps are only taken at reset release, so a reset follows the change.
		strap <= 8'h00;
		dev_pulse(1'b0);
		tick(6);
		toggles(n);
		check("strap off", 32'(n) | 32'(rck), 32'h0);
		check("strap sel lo", 32'(rsel), 32'h0);
		strap <= 8'h03;
		$display("reference clock test done");
	endtask

	task automatic t_dev_reset();
		wb(1'b1, OFF_INT_MSK, 32'h3ff);
		dev_n <= 1'b0;
		tick(4);
		check("powered down", 32'(pdown), 32'h1);
		toggles(n);
		check("clock in reset", 32'(n) | 32'(rck), 32'h0);
		dev_n <= 1'b1;
		wait_done();
		wb(1'b0, OFF_INT_MSK, 32'h0);
		check("mask default", rdat, 32'h0);
		$display("device reset test done");
	endtask

	task automatic t_eeprom();
		logic [7:0] b;
		dev_pulse(1'b1);
		tick(10);
		wb(1'b0, OFF_STATUS, 32'h0);
		check("eeprom seen", 32'(rdat[1:0]), 32'h1);
		wait_lvl(1'b0, 1'b1);
		check("start scl", 32'(scl), 32'h1);
		for (int i = 7; i >= 0; i--) begin
			wait_lvl(1'b1, 1'b0);
			wait_lvl(1'b1, 1'b1);
			b[i] = sda_ln;
		end
		check("device byte", 32'(b), 32'(EE_DEV_WR));
		dev_pulse(1'b0);
		wait_done();
		check("no eeprom", rdat, 32'h00000f02);
		$display("eeprom test done");
	endtask

	task automatic test_done();
		$display("compares %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	initial begin
		rst = 1'b1;
		{cyc, stb, we, sel, adr, wdat, ev} = '0;
		{dev_n, ee_pull, pull, strap} = {1'b1, 1'b0, 8'h0f, 8'h03};
		err_count = 0;
		cmp_count = 0;
		tick(16);
		rst <= 1'b0;
		t_defaults();
		t_irq();
		t_mgmt();
		t_refclk();
		t_dev_reset();
		t_eeprom();
		test_done();
	end

	initial begin
		tick(40000);
		err_count++;
		$display("[FAIL] watchdog expected finish seen timeout");
		test_done();
	end
endmodule
